// ==== hdl/handshake_pkg.sv ====
/*
  Constants for the robot host handshake sequencer: error display codes,
  pulse widths and timing counts.
  Assumes a 40 MHz system clock and no register bus other than APB.
*/
package handshake_pkg;
  localparam int unsigned  CLK_HZ           = 40_000_000;
  // Error display codes shown on the panel (decimal digits in a byte)
  localparam logic [7:0]   CODE_NONE        = 8'h00;
  localparam logic [7:0]   CODE_POSITION    = 8'h02;
  localparam logic [7:0]   CODE_IRON_TIME   = 8'h03;
  localparam logic [7:0]   CODE_WAIT_TIME   = 8'h04;
  localparam logic [7:0]   CODE_TEMP        = 8'h06;
  localparam logic [7:0]   CODE_DATA_CHECK  = 8'h08;
  localparam logic [7:0]   CODE_UPPER_LIMIT = 8'h09;
  // END output pulse width
  localparam int unsigned  END_PULSE_US     = 100;
  localparam int unsigned  END_PULSE_CYC    =
    (END_PULSE_US * (CLK_HZ / 1_000_000) > 0) ?
    END_PULSE_US * (CLK_HZ / 1_000_000) : 1;
  localparam int unsigned  PROG_W           = 7;
  localparam int unsigned  CNT_W            = 16;
  // APB map
  localparam logic [11:0]  ADDR_CTRL        = 12'h000;
  localparam logic [11:0]  ADDR_STATUS      = 12'h004;
  localparam logic [11:0]  ADDR_PROG_VALID  = 12'h008;
  localparam logic [11:0]  ADDR_PROGRAM     = 12'h00C;
  localparam int unsigned  CTRL_HOME_EMG    = 0;
  localparam logic [31:0]  CTRL_RESET_VAL   = 32'h0000_0001;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_HOME_Z, ST_HOME_XYT, ST_WAIT_TEMP, ST_READY, ST_RUN,
    ST_PAUSE_DRAIN, ST_PAUSED, ST_ERROR, ST_EMERG
  } seq_state_t;
endpackage : handshake_pkg

// ==== hdl/robot_host_handshake_sequencer.sv ====
/*
  Discrete-I/O handshake and run sequencer of a soldering robot
  controller. Host-side inputs pass a three-flop synchroniser; motion and
  heater blocks on the same clock report through plain status inputs.
  Software reaches a small register set over APB.
*/
`timescale 1ns/10ps
module robot_host_handshake_sequencer (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Host pins, asynchronous
  input  wire logic         home_in,
  input  wire logic         start_in,
  input  wire logic         pause_in,
  input  wire logic         reset_in,
  input  wire logic         emergency_contact,
  input  wire logic [6:0]   program_number_inputs,
  // Host outputs
  output logic              ready_out,
  output logic              running_out,
  output logic              end_out,
  output logic              error_out,
  // Motion and heater status, same clock
  input  wire logic         z_at_origin,
  input  wire logic         xyt_at_origin,
  input  wire logic         tip_temp_ok,
  input  wire logic         heater_fault,
  input  wire logic         step_out,
  input  wire logic         iron_time_over,
  input  wire logic         wait_time_over,
  input  wire logic         upper_sensor_ok,
  input  wire logic         solder_shortage,
  input  wire logic         solder_step_active,
  input  wire logic         program_done,
  // Motion and heater commands
  output logic              home_z_cmd,
  output logic              home_xyt_cmd,
  output logic              heater_on,
  output logic              axis_enable,
  output logic              program_restart,
  output logic [6:0]        program_number_select,
  output logic [7:0]        error_code,
  output logic              temp_error_lamp,
  output logic              shortage_lamp
);
  localparam int unsigned NSYNC = 12;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 12'h010; // Only emergency rests high

  handshake_pkg::seq_state_t state_reg;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] pin_reg;
  logic [NSYNC-1:0] pin_prev_reg;
  logic [31:0]      ctrl_reg;
  logic [127:0]     prog_valid_reg;
  logic [handshake_pkg::CNT_W-1:0] end_cnt_reg;
  logic             emerg_latched_reg;
  logic             restart_reg;
  logic             need_home_reg;
  logic             need_reselect_reg;
  logic [6:0]       last_prog_reg;

  logic             home_s;
  logic             start_s;
  logic             pause_s;
  logic             reset_s;
  logic             emerg_closed_s;
  logic [6:0]       prog_s;
  logic             start_rise;
  logic             home_rise;
  logic             reset_rise;
  logic             emerg_fall;
  logic             emerg_rise;
  logic             apb_wr;
  logic             apb_rd;
  logic             addr_ok;
  logic             idle_blocked;

  // Weighted sum of asserted select lines
  function automatic logic [6:0] prog_number(input logic [6:0] sel);
    logic [6:0] sum;
    sum = 7'h00;
    for (int i = 0; i < 7; i++)
    begin
      if (sel[i])
        sum = sum | 7'(1 << i);
    end
    return sum;
  endfunction : prog_number

  // Three-flop synchroniser; a change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg       <= SYNC_IDLE;
      s2_reg       <= SYNC_IDLE;
      s3_reg       <= SYNC_IDLE;
      pin_reg      <= SYNC_IDLE;
      pin_prev_reg <= SYNC_IDLE;
    end
    else if (clk_en)
    begin
      s1_reg <= {program_number_inputs, emergency_contact, reset_in,
                 pause_in, start_in, home_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NSYNC; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          pin_reg[i] <= s3_reg[i];
      end
      pin_prev_reg <= pin_reg;
    end
  end

  assign home_s         = pin_reg[0];
  assign start_s        = pin_reg[1];
  assign pause_s        = pin_reg[2];
  assign reset_s        = pin_reg[3];
  assign emerg_closed_s = pin_reg[4];
  assign prog_s         = prog_number(pin_reg[11:5]);
  assign start_rise     = start_s & ~pin_prev_reg[1];
  assign home_rise      = home_s  & ~pin_prev_reg[0];
  assign reset_rise     = reset_s & ~pin_prev_reg[3];
  assign emerg_fall     = ~emerg_closed_s & pin_prev_reg[4];
  assign emerg_rise     = emerg_closed_s & ~pin_prev_reg[4];

  // Idle faults that hold READY low
  assign idle_blocked = heater_fault | ~tip_temp_ok | ~upper_sensor_ok;

  // APB decode, zero wait states
  assign apb_wr  = psel & penable & pwrite & clk_en;
  assign apb_rd  = psel & ~pwrite;
  assign addr_ok = (paddr == handshake_pkg::ADDR_CTRL) |
                   (paddr == handshake_pkg::ADDR_STATUS) |
                   (paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00 &&
                    paddr[3:2] == 2'b10) |
                   (paddr[11:4] == 8'h01 && paddr[1:0] == 2'b00) |
                   (paddr == handshake_pkg::ADDR_PROGRAM);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Control and program-defined table; writes at the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg       <= handshake_pkg::CTRL_RESET_VAL;
      prog_valid_reg <= '0;
    end
    else if (apb_wr && addr_ok)
    begin
      if (paddr == handshake_pkg::ADDR_CTRL)
        ctrl_reg <= pwdata;
      else if (paddr[11:4] == 8'h00 && paddr[3:2] == 2'b10)
        prog_valid_reg[31:0] <= pwdata;
      else if (paddr[11:4] == 8'h01)
        prog_valid_reg[32*paddr[3:2] +: 32] <= pwdata;
    end
  end

  // Read data mux, registered on the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && apb_rd && !penable)
    begin
      if (paddr == handshake_pkg::ADDR_CTRL)
        prdata <= ctrl_reg;
      else if (paddr == handshake_pkg::ADDR_STATUS)
        prdata <= {16'h0000, error_code, 4'h0, state_reg};
      else if (paddr == handshake_pkg::ADDR_PROGRAM)
        prdata <= {25'h000_0000, program_number_select};
      else if (paddr[11:4] == 8'h00 && paddr[3:2] == 2'b10)
        prdata <= prog_valid_reg[31:0];
      else if (paddr[11:4] == 8'h01)
        prdata <= prog_valid_reg[32*paddr[3:2] +: 32];
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Main sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg             <= handshake_pkg::ST_IDLE;
      error_code            <= handshake_pkg::CODE_NONE;
      program_number_select <= 7'h00;
      emerg_latched_reg     <= 1'b0;
      restart_reg           <= 1'b1;
      need_home_reg         <= 1'b0;
      need_reselect_reg     <= 1'b0;
      last_prog_reg         <= 7'h00;
    end
    else if (clk_en)
    begin
      if (!emerg_closed_s)
      begin
        state_reg         <= handshake_pkg::ST_EMERG;
        emerg_latched_reg <= 1'b1;
      end
      else
      case (state_reg)
        handshake_pkg::ST_IDLE:
          if (home_rise)
            state_reg <= handshake_pkg::ST_HOME_Z;
        handshake_pkg::ST_HOME_Z:
          if (z_at_origin)
            state_reg <= handshake_pkg::ST_HOME_XYT;
        handshake_pkg::ST_HOME_XYT:
          if (xyt_at_origin)
            state_reg <= handshake_pkg::ST_WAIT_TEMP;
        handshake_pkg::ST_WAIT_TEMP:
          if (tip_temp_ok && z_at_origin && xyt_at_origin)
          begin
            state_reg     <= handshake_pkg::ST_READY;
            need_home_reg <= 1'b0;
          end
        handshake_pkg::ST_READY:
        begin
          if (heater_fault)
            error_code <= handshake_pkg::CODE_TEMP;
          else if (error_code == handshake_pkg::CODE_TEMP)
            error_code <= handshake_pkg::CODE_NONE;
          if (start_rise && !upper_sensor_ok)
          begin
            state_reg  <= handshake_pkg::ST_ERROR;
            error_code <= handshake_pkg::CODE_UPPER_LIMIT;
          end
          else if (start_rise && !idle_blocked)
          begin
            if (!prog_valid_reg[prog_s] ||
                (need_reselect_reg && prog_s == last_prog_reg))
            begin
              state_reg     <= handshake_pkg::ST_ERROR;
              error_code    <= handshake_pkg::CODE_DATA_CHECK;
              need_home_reg <= 1'b1;
            end
            else
            begin
              state_reg             <= handshake_pkg::ST_RUN;
              program_number_select <= prog_s;
              restart_reg           <= (prog_s != last_prog_reg) |
                                       restart_reg;
              last_prog_reg         <= prog_s;
              need_reselect_reg     <= 1'b0;
            end
          end
        end
        handshake_pkg::ST_PAUSED:
          if (start_rise)
            state_reg <= handshake_pkg::ST_RUN;
        handshake_pkg::ST_RUN,
        handshake_pkg::ST_PAUSE_DRAIN:
        begin
          restart_reg <= 1'b0;
          if (step_out)
          begin
            state_reg         <= handshake_pkg::ST_ERROR;
            error_code        <= handshake_pkg::CODE_POSITION;
            need_home_reg     <= 1'b1;
            need_reselect_reg <= 1'b1;
          end
          else if (iron_time_over || !upper_sensor_ok)
          begin
            state_reg         <= handshake_pkg::ST_ERROR;
            error_code        <= handshake_pkg::CODE_IRON_TIME;
          end
          else if (wait_time_over)
          begin
            state_reg         <= handshake_pkg::ST_ERROR;
            error_code        <= handshake_pkg::CODE_WAIT_TIME;
            restart_reg       <= 1'b1;
          end
          else if (heater_fault)
          begin
            state_reg  <= handshake_pkg::ST_ERROR;
            error_code <= handshake_pkg::CODE_TEMP;
          end
          else if (solder_shortage && !solder_step_active)
            state_reg <= handshake_pkg::ST_ERROR;
          else if (program_done && state_reg == handshake_pkg::ST_RUN)
          begin
            state_reg   <= handshake_pkg::ST_READY;
            restart_reg <= 1'b1;
          end
          else if ((pause_s || state_reg == handshake_pkg::ST_PAUSE_DRAIN)
                   && !solder_step_active)
            state_reg <= handshake_pkg::ST_PAUSED;
          else if (pause_s)
            state_reg <= handshake_pkg::ST_PAUSE_DRAIN;
        end
        handshake_pkg::ST_ERROR:
          if (error_code == handshake_pkg::CODE_NONE)
          begin
            if (!solder_shortage)
              state_reg <= handshake_pkg::ST_PAUSED;
          end
          else if (reset_rise && !heater_fault && upper_sensor_ok)
          begin
            error_code <= handshake_pkg::CODE_NONE;
            if (need_home_reg)
              state_reg <= handshake_pkg::ST_IDLE;
            else
              state_reg <= handshake_pkg::ST_READY;
          end
        handshake_pkg::ST_EMERG:
        begin
          if (emerg_rise && ctrl_reg[handshake_pkg::CTRL_HOME_EMG])
            state_reg <= handshake_pkg::ST_HOME_Z;
          else if (home_rise || reset_rise)
            state_reg <= handshake_pkg::ST_HOME_Z;
          error_code        <= handshake_pkg::CODE_NONE;
          emerg_latched_reg <= 1'b0;
        end
        default:
          state_reg <= handshake_pkg::ST_IDLE;
      endcase
    end
  end

  // END pulse, raised together with READY at a normal finish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      end_cnt_reg <= '0;
    else if (clk_en)
    begin
      if (emerg_closed_s && state_reg == handshake_pkg::ST_RUN &&
          program_done && !step_out && !iron_time_over &&
          upper_sensor_ok && !wait_time_over && !heater_fault &&
          !(solder_shortage && !solder_step_active))
        end_cnt_reg <= handshake_pkg::CNT_W'(handshake_pkg::END_PULSE_CYC);
      else if (end_cnt_reg != '0)
        end_cnt_reg <= end_cnt_reg - 1'b1;
    end
  end

  // Host outputs and motion commands
  assign running_out = emerg_closed_s &&
                       (state_reg == handshake_pkg::ST_RUN ||
                        state_reg == handshake_pkg::ST_PAUSE_DRAIN);
  assign ready_out   = state_reg == handshake_pkg::ST_READY &&
                       !idle_blocked;
  assign end_out     = end_cnt_reg != '0;
  assign error_out   = state_reg == handshake_pkg::ST_ERROR;
  assign home_z_cmd  = state_reg == handshake_pkg::ST_HOME_Z;
  assign home_xyt_cmd = state_reg == handshake_pkg::ST_HOME_XYT;
  assign heater_on   = emerg_closed_s &&
                       state_reg != handshake_pkg::ST_EMERG;
  assign axis_enable = running_out;
  assign program_restart = restart_reg;
  assign temp_error_lamp = ~tip_temp_ok | heater_fault;
  assign shortage_lamp   = solder_shortage;
endmodule : robot_host_handshake_sequencer

// ==== test/handshake_chk.sv ====
/*
  Port assertions for the robot host handshake sequencer.
  Bound to the sequencer top; one clock, async active-low reset.
*/
`timescale 1ns/10ps
module handshake_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        emergency_contact,
  input wire logic        ready_out,
  input wire logic        running_out,
  input wire logic        end_out,
  input wire logic        error_out,
  input wire logic        z_at_origin,
  input wire logic        xyt_at_origin,
  input wire logic        tip_temp_ok,
  input wire logic        home_z_cmd,
  input wire logic        home_xyt_cmd,
  input wire logic        heater_on,
  input wire logic        temp_error_lamp
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Homing step and the normal close of a run
  sequence z_home_done_s;
    z_at_origin && !home_z_cmd;
  endsequence
  sequence run_closed_s;
    ready_out && !running_out && end_out;
  endsequence

  // Homing order and readiness
  z_first_a: assert property ($rose(home_xyt_cmd) |-> z_home_done_s)
    else $error("xyt homing began before z origin");
  ready_gate_a: assert property ($rose(ready_out) |->
    z_at_origin && xyt_at_origin && tip_temp_ok)
    else $error("ready raised before homing and heating");
  // Run handshake
  ready_excl_a: assert property (!(ready_out && running_out))
    else $error("ready and running high together");
  end_sync_a: assert property ($fell(running_out) && ready_out |->
    run_closed_s)
    else $error("end not raised with ready at run end");
  emg_stop_a: assert property ((!emergency_contact) [*8] |->
    !running_out && !heater_on)
    else $error("run or heater kept while emergency open");
  err_halt_a: assert property (error_out |->
    !ready_out && !running_out)
    else $error("error shown while ready or running");
  temp_lamp_a: assert property (running_out && temp_error_lamp |->
    !error_out)
    else $error("temperature lamp in run raised error");
  // Register bus answers
  apb_err_a: assert property (psel && penable && paddr > 12'h01C |->
    pslverr && pready)
    else $error("unmapped access not refused");
  apb_ok_a: assert property (psel && penable && paddr <= 12'h01C &&
    paddr[1:0] == 2'b00 |-> !pslverr && pready)
    else $error("mapped access refused");
endmodule : handshake_chk

bind robot_host_handshake_sequencer handshake_chk chk (.*);

// ==== test/host_plc_model.sv ====
/*
  Host controller model: drives the handshake pins of the sequencer.
  Assumes the bench clock; buttons are held long enough to pass sync.
*/
`timescale 1ns/10ps
module host_plc_model (
  input  wire logic  pclk,
  input  wire logic  running_out,
  input  wire logic  error_out,
  output logic       home_in,
  output logic       start_in,
  output logic       pause_in,
  output logic       reset_in,
  output logic       emergency_contact,
  output logic [6:0] program_number_inputs
);
  // Idle pins, emergency loop closed
  initial
  begin
    {home_in, start_in, pause_in, reset_in} = 4'h0;
    emergency_contact = 1'b1;
    program_number_inputs = 7'h00;
  end

  // Press home (0), pause (1) or reset (2) for 8 cycles
  task automatic press(input int which);
    @(posedge pclk);
    {reset_in, pause_in, home_in} <= 3'b001 << which;
    repeat (8) @(posedge pclk);
    {reset_in, pause_in, home_in} <= 3'b000;
    repeat (8) @(posedge pclk);
  endtask : press

  // Select, start, then release start and invert the select once run or error is seen after 8 cycles, or after 48 cycles at most
  task automatic start_run(input logic [6:0] prog);
    int n;
    @(posedge pclk);
    program_number_inputs <= prog;
    repeat (8) @(posedge pclk);
    start_in <= 1'b1;
    n = 0;
    repeat (8) @(posedge pclk);
    while (running_out !== 1'b1 && error_out !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    start_in <= 1'b0;
    program_number_inputs <= ~prog;
    repeat (8) @(posedge pclk);
  endtask : start_run

  // Open or close the emergency loop
  task automatic emergency_restored(input logic closed);
    @(posedge pclk);
    emergency_contact <= closed;
    repeat (8) @(posedge pclk);
  endtask : emergency_restored
endmodule : host_plc_model

// ==== test/test_robot_host_handshake_sequencer.sv ====
/*
  Testbench: registers, homing, runs, pause, faults and emergency.
  Assumes an axis plant that reaches origin one cycle after a command.
*/
`timescale 1ns/10ps
module test_robot_host_handshake_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  wire logic   home_in, start_in, pause_in, reset_in, emergency_contact;
  wire logic [6:0] program_number_inputs;
  logic        ready_out, running_out, end_out, error_out, step_out;
  logic        z_at_origin, xyt_at_origin, tip_temp_ok, heater_fault;
  logic        iron_time_over, wait_time_over, upper_sensor_ok;
  logic        solder_shortage, solder_step_active, program_done;
  logic        home_z_cmd, home_xyt_cmd, heater_on, axis_enable;
  logic        program_restart, temp_error_lamp, shortage_lamp, clk_en;
  logic [6:0]  program_number_select;
  logic [7:0]  error_code;
  logic [7:0]  codes [4];
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  robot_host_handshake_sequencer dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .home_in(home_in), .start_in(start_in), .pause_in(pause_in),
    .reset_in(reset_in), .emergency_contact(emergency_contact),
    .program_number_inputs(program_number_inputs),
    .ready_out(ready_out), .running_out(running_out), .end_out(end_out),
    .error_out(error_out), .z_at_origin(z_at_origin),
    .xyt_at_origin(xyt_at_origin), .tip_temp_ok(tip_temp_ok),
    .heater_fault(heater_fault), .step_out(step_out),
    .iron_time_over(iron_time_over), .wait_time_over(wait_time_over),
    .upper_sensor_ok(upper_sensor_ok), .solder_shortage(solder_shortage),
    .solder_step_active(solder_step_active), .program_done(program_done),
    .home_z_cmd(home_z_cmd), .home_xyt_cmd(home_xyt_cmd),
    .heater_on(heater_on), .axis_enable(axis_enable),
    .program_restart(program_restart),
    .program_number_select(program_number_select),
    .error_code(error_code), .temp_error_lamp(temp_error_lamp),
    .shortage_lamp(shortage_lamp));
  host_plc_model plc (
    .pclk(pclk), .running_out(running_out), .error_out(error_out),
    .home_in(home_in), .start_in(start_in), .pause_in(pause_in),
    .reset_in(reset_in), .emergency_contact(emergency_contact),
    .program_number_inputs(program_number_inputs));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Axis plant: origin is lost while the emergency loop is open
  always @(posedge pclk)
  begin
    if (!emergency_contact)
      {z_at_origin, xyt_at_origin} <= 2'b00;
    else
      {z_at_origin, xyt_at_origin} <= {z_at_origin | home_z_cmd,
                                       xyt_at_origin | home_xyt_cmd};
  end

  // Cut a hang short
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready at an access edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (!(pready === 1'b1 && penable === 1'b1));
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic sig(input int w);
    case (w)
      0: return ready_out;
      default: return error_out;
    endcase
  endfunction : sig

  // Bounded wait for ready (0) or error (1)
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
  endtask : wait_on

  task automatic fault(input int k, input logic v);
    iron_time_over  <= v && k == 0;
    wait_time_over  <= v && k == 1;
    heater_fault    <= v && k == 2;
    upper_sensor_ok <= !(v && k == 3);
    step_out        <= v && k == 4;
    solder_shortage <= v && k == 5;
  endtask : fault

  task automatic run(input logic [6:0] p);
    plc.start_run(p);
    check("running", 32'({ready_out, running_out}), 32'h1);
  endtask : run

  task automatic finish_run();
    program_done <= 1'b1;
    @(posedge pclk);
    program_done <= 1'b0;
    wait_on(0);
  endtask : finish_run

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tip_temp_ok, heater_fault, step_out, iron_time_over} = '0;
    {wait_time_over, solder_shortage, solder_step_active} = '0;
    {program_done, z_at_origin, xyt_at_origin} = '0;
    {upper_sensor_ok, clk_en} = 2'b11;
    codes = '{handshake_pkg::CODE_IRON_TIME, handshake_pkg::CODE_WAIT_TIME,
              handshake_pkg::CODE_TEMP, handshake_pkg::CODE_IRON_TIME};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, handshake_pkg::ADDR_CTRL, '0);
    check("ctrl", q, handshake_pkg::CTRL_RESET_VAL);
    apb(1'b1, handshake_pkg::ADDR_PROG_VALID, 32'h0000_0060);
    apb(1'b1, 12'h018, 32'h0000_0020);
    apb(1'b0, handshake_pkg::ADDR_PROG_VALID, '0);
    check("prog valid", q, 32'h0000_0060);
    apb(1'b0, 12'h100, '0);
    check("unmapped", {e, q[30:0]}, 32'h8000_0000);
    $display("registers done");
    plc.press(0);
    check("ready cold", 32'(ready_out), 32'h0);
    tip_temp_ok <= 1'b1;
    wait_on(0);
    check("ready hot", 32'(ready_out), 32'h1);
    run(7'h45);
    check("prog select", 32'(program_number_select), 32'h45);
    finish_run();
    check("end", 32'({ready_out, running_out, end_out}), 32'h5);
    $display("homing and run done");
    run(7'h05);
    solder_step_active <= 1'b1;
    plc.press(1);
    check("drain", 32'(axis_enable), 32'h1);
    solder_step_active <= 1'b0;
    repeat (4) @(posedge pclk);
    check("paused", 32'(axis_enable), 32'h0);
    run(7'h05);
    check("resume", 32'(program_restart), 32'h0);
    finish_run();
    $display("pause done");
    // Faults cleared by the reset button
    for (int k = 0; k < 4; k++)
    begin
      run(7'h05);
      fault(k, 1'b1);
      wait_on(1);
      check("err code", 32'(error_code), 32'(codes[k]));
      fault(k, 1'b0);
      plc.press(2);
      wait_on(0);
      check("restart", 32'(program_restart), 32'(k == 1));
    end
    $display("faults done");
    run(7'h05);
    fault(5, 1'b1);
    wait_on(1);
    check("shortage", 32'({error_out, shortage_lamp}), 32'h3);
    fault(5, 1'b0);
    repeat (10) @(posedge pclk);
    check("shortage clear", 32'(error_out), 32'h0);
    run(7'h05);
    solder_step_active <= 1'b1;
    tip_temp_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    check("lamp", 32'({temp_error_lamp, error_out, running_out}), 32'h5);
    {tip_temp_ok, solder_step_active} <= 2'b10;
    finish_run();
    heater_fault <= 1'b1;
    repeat (10) @(posedge pclk);
    check("idle temp", 32'({ready_out, error_code}), 32'h6);
    plc.start_run(7'h05);
    check("start refused", 32'(running_out), 32'h0);
    heater_fault <= 1'b0;
    plc.press(2);
    wait_on(0);
    upper_sensor_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    check("upper lost", 32'(ready_out), 32'h0);
    plc.start_run(7'h05);
    check("upper err", 32'({error_out, error_code}), 32'h0000_0109);
    upper_sensor_ok <= 1'b1;
    plc.press(2);
    wait_on(0);
    plc.start_run(7'h21);
    check("no prog", 32'({error_out, error_code}), 32'h0000_0108);
    plc.press(2);
    plc.emergency_restored(1'b0);
    plc.emergency_restored(1'b1);
    wait_on(0);
    check("prog recover", 32'(ready_out), 32'h1);
    $display("idle errors done");
    run(7'h05);
    fault(4, 1'b1);
    wait_on(1);
    check("step out", 32'(error_code), 32'h2);
    fault(4, 1'b0);
    plc.emergency_restored(1'b0);
    plc.emergency_restored(1'b1);
    wait_on(0);
    run(7'h06);
    plc.emergency_restored(1'b0);
    check("emg halt", 32'({running_out, heater_on}), 32'h0);
    apb(1'b1, handshake_pkg::ADDR_CTRL, '0);
    plc.emergency_restored(1'b1);
    repeat (20) @(posedge pclk);
    check("no auto home", 32'(ready_out), 32'h0);
    plc.press(0);
    wait_on(0);
    check("ready again", 32'(ready_out), 32'h1);
    // A frozen block ignores START; it works again once enabled
    clk_en <= 1'b0;
    plc.start_run(7'h05);
    check("frozen", 32'(running_out), 32'h0);
    clk_en <= 1'b1;
    run(7'h05);
    $display("emergency done");
    summarize();
  end
endmodule : test_robot_host_handshake_sequencer
